// File: psm_top.v
// The placing of the registers and register access over APB were left to the implementer.
`timescale 1ns/1ps
`include "psm_map.vh"
module psm_top (
   // apb slave
   input  wire        pclk,
   input  wire        presetn,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [7:0]  paddr,
   input  wire [31:0] pwdata,
   output wire [31:0] prdata,
   output wire        pready,
   output wire        pslverr,
   // pads
   input  wire [87:0] pad_in,
   output wire [87:0] pad_out,
   output wire [87:0] pad_oe,
   // external bus controller side
   input  wire [7:0]  bus_low_byte_out,
   input  wire [7:0]  bus_low_byte_oe,
   input  wire [7:0]  bus_high_byte_out,
   input  wire [7:0]  bus_high_byte_oe,
   input  wire [7:0]  addr_low_byte,
   input  wire [7:0]  addr_mid_byte,
   input  wire [2:0]  addr_upper_lines_a,
   input  wire [4:0]  addr_upper_lines_b,
   input  wire        bus_clk_out,
   input  wire        read_strobe_n,
   input  wire        write_strobe_hi_n,
   input  wire        write_strobe_lo_n,
   input  wire        hold_ack_out,
   output wire [7:0]  bus_low_byte_in,
   output wire [7:0]  bus_high_byte_in,
   output wire        bus_ready_in,
   output wire        hold_request_in,
   output wire        ram_lock_request,
   // timer, compare and capture side
   input  wire [7:0]  compare_out,
   input  wire [5:0]  reload_timer_out,
   input  wire [1:0]  pulse_gen_out,
   input  wire [3:0]  pulse_width_out,
   input  wire [3:0]  pulse_width_out_act,
   output wire [4:0]  reload_timer_in,
   output wire [3:0]  capture_in,
   output wire [3:0]  pulse_width_in,
   output wire [1:0]  ext_irq_in_lower,
   output wire [4:0]  ext_irq_in_upper,
   // converter channel enables
   output wire [7:0]  analog_in_group_a,
   output wire [7:0]  analog_in_group_b,
   // mode status
   output wire        ext_bus_mode
);
   // configuration state
   reg  [12:0] ctrl_reg;
   reg  [15:0] ana_reg;
   reg  [6:0]  irqen_reg;
   reg  [7:0]  data_reg [0:10];
   reg  [7:0]  dir_reg  [0:10];
   // apb answer state
   reg  [31:0] prdata_reg;
   reg  [31:0] prdata_next;
   reg         pready_reg;
   reg         pslverr_reg;
   reg         pslverr_next;
   // pad and peripheral outputs
   reg  [87:0] pad_out_reg;
   reg  [87:0] pad_oe_reg;
   wire [87:0] pad_out_next;
   wire [87:0] pad_oe_next;
   reg  [7:0]  lo_in_reg;
   reg  [7:0]  hi_in_reg;
   reg         rdy_reg;
   reg         hrq_reg;
   reg         lock_reg;
   reg  [4:0]  tin_reg;
   reg  [3:0]  cap_reg;
   reg  [3:0]  pwc_reg;
   reg  [1:0]  irq_lo_reg;
   reg  [4:0]  irq_hi_reg;
   reg  [15:0] ana_out_reg;
   reg         ext_reg;
   // alternate function selection
   reg  [87:0] alt_sel;
   reg  [87:0] alt_out;
   reg  [87:0] alt_oe;
   wire [87:0] pin_lvl;
   wire [3:0]  reg_idx;
   wire [1:0]  reg_grp;
   wire        idx_ok;
   wire        wr_ok;
   wire        ext;
   wire        bus16;
   integer     k;

   // pad levels are asynchronous, synchronise before use
   psm_sync #(
      .WIDTH   (`PSM_NPIN)
   ) u_pad_sync (
      .pclk    (pclk),
      .presetn (presetn),
      .d_in    (pad_in),
      .d_out   (pin_lvl)
   );

   // register decode
   assign reg_grp = paddr[7:6];
   assign reg_idx = paddr[5:2];
   assign idx_ok  = (reg_idx < `PSM_NPORT) && (paddr[1:0] == 2'b00);
   assign wr_ok   = psel & penable & pready_reg & pwrite;
   assign ext     = ctrl_reg[`PSM_C_EXT];
   assign bus16   = ctrl_reg[`PSM_C_BUS16];

   // read data and error for the addressed register
   always @* begin
      prdata_next  = 32'h0000_0000;
      pslverr_next = 1'b0;
      if (reg_grp == 2'b00) begin
         case (paddr)
            `PSM_OFF_CTRL:  prdata_next = {19'h00000, ctrl_reg};
            `PSM_OFF_ANA:   prdata_next = {16'h0000, ana_reg};
            `PSM_OFF_IRQEN: prdata_next = {25'h0000000, irqen_reg};
            default:        pslverr_next = 1'b1;
         endcase
      end else if (!idx_ok) begin
         pslverr_next = 1'b1;
      end else begin
         case (reg_grp)
            `PSM_BASE_DATA: prdata_next = {24'h000000, data_reg[reg_idx]};
            `PSM_BASE_DIR:  prdata_next = {24'h000000, dir_reg[reg_idx]};
            // pin levels, sampled whatever function owns the pin
            `PSM_BASE_PIN:  prdata_next =
                               {24'h000000, pin_lvl[{reg_idx, 3'b000} +: 8]};
            default:        prdata_next = 32'h0000_0000;
         endcase
      end
   end

   // apb handshake: one wait-free access cycle after setup
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_reg  <= 1'b0;
         prdata_reg  <= 32'h0000_0000;
         pslverr_reg <= 1'b0;
      end else begin
         pready_reg <= psel & ~penable & ~pready_reg;
         if (psel & ~penable) begin
            prdata_reg  <= pwrite ? 32'h0000_0000 : prdata_next;
            // error only where ready rises with it
            pslverr_reg <= pslverr_next & ~pready_reg;
         end else if (pready_reg) begin
            pslverr_reg <= 1'b0;
         end
      end
   end

   // configuration writes, ignored on error
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_reg  <= `PSM_CTRL_RST;
         ana_reg   <= `PSM_ANA_RST;
         irqen_reg <= `PSM_IRQ_RST;
         for (k = 0; k < 11; k = k + 1) begin
            data_reg[k] <= `PSM_PORT_RST;
            dir_reg[k]  <= `PSM_PORT_RST;
         end
      end else if (wr_ok && !pslverr_reg) begin
         if (reg_grp == 2'b00) begin
            case (paddr)
               `PSM_OFF_CTRL:  ctrl_reg  <= pwdata[12:0];
               `PSM_OFF_ANA:   ana_reg   <= pwdata[15:0];
               `PSM_OFF_IRQEN: irqen_reg <= pwdata[6:0];
               default:        ctrl_reg  <= ctrl_reg;
            endcase
         end else if (reg_grp == `PSM_BASE_DATA) begin
            data_reg[reg_idx] <= pwdata[7:0];
         end else if (reg_grp == `PSM_BASE_DIR) begin
            dir_reg[reg_idx] <= pwdata[7:0];
         end
      end
   end

   // alternate functions claiming pins
   always @* begin
      alt_sel = {`PSM_NPIN{1'b0}};
      alt_out = {`PSM_NPIN{1'b0}};
      alt_oe  = {`PSM_NPIN{1'b0}};
      if (ext) begin
         // low data byte
         alt_sel[`PSM_B0+7:`PSM_B0] = 8'hff;
         alt_out[`PSM_B0+7:`PSM_B0] = bus_low_byte_out;
         alt_oe[`PSM_B0+7:`PSM_B0]  = bus_low_byte_oe;
         // low address byte
         alt_sel[`PSM_B2+7:`PSM_B2] = 8'hff;
         alt_out[`PSM_B2+7:`PSM_B2] = addr_low_byte;
         alt_oe[`PSM_B2+7:`PSM_B2]  = 8'hff;
         // read strobe
         alt_sel[`PSM_B5+6] = 1'b1;
         alt_out[`PSM_B5+6] = read_strobe_n;
         alt_oe[`PSM_B5+6]  = 1'b1;
      end
      if (ext && bus16) begin
         alt_sel[`PSM_B1+7:`PSM_B1] = 8'hff;
         alt_out[`PSM_B1+7:`PSM_B1] = bus_high_byte_out;
         alt_oe[`PSM_B1+7:`PSM_B1]  = bus_high_byte_oe;
      end
      if (ext && ctrl_reg[`PSM_C_MID]) begin
         alt_sel[`PSM_B3+7:`PSM_B3] = 8'hff;
         alt_out[`PSM_B3+7:`PSM_B3] = addr_mid_byte;
         alt_oe[`PSM_B3+7:`PSM_B3]  = 8'hff;
      end
      if (ext && ctrl_reg[`PSM_C_HI]) begin
         alt_sel[`PSM_B4+7:`PSM_B4] = 8'hff;
         alt_out[`PSM_B4+7:`PSM_B4] = {addr_upper_lines_b, addr_upper_lines_a};
         alt_oe[`PSM_B4+7:`PSM_B4]  = 8'hff;
      end
      if (ext && ctrl_reg[`PSM_C_CLK]) begin
         alt_sel[`PSM_B5+0] = 1'b1;
         alt_out[`PSM_B5+0] = bus_clk_out;
         alt_oe[`PSM_B5+0]  = 1'b1;
      end
      if (ext && ctrl_reg[`PSM_C_RDY]) begin
         alt_sel[`PSM_B5+1] = 1'b1;
      end
      if (ext && ctrl_reg[`PSM_C_HOLD]) begin
         alt_sel[`PSM_B5+2] = 1'b1;
         alt_out[`PSM_B5+2] = hold_ack_out;
         alt_oe[`PSM_B5+2]  = 1'b1;
         alt_sel[`PSM_B5+3] = 1'b1;
      end
      if (ext && bus16 && ctrl_reg[`PSM_C_WRH]) begin
         alt_sel[`PSM_B5+4] = 1'b1;
         alt_out[`PSM_B5+4] = write_strobe_hi_n;
         alt_oe[`PSM_B5+4]  = 1'b1;
      end
      if (ext && ctrl_reg[`PSM_C_WRL]) begin
         alt_sel[`PSM_B5+5] = 1'b1;
         alt_out[`PSM_B5+5] = write_strobe_lo_n;
         alt_oe[`PSM_B5+5]  = 1'b1;
      end
      if (ctrl_reg[`PSM_C_CMP]) begin
         alt_sel[`PSM_B7+7:`PSM_B7] = 8'hff;
         alt_out[`PSM_B7+7:`PSM_B7] = compare_out;
         alt_oe[`PSM_B7+7:`PSM_B7]  = 8'hff;
      end
      if (ctrl_reg[`PSM_C_RT]) begin
         alt_sel[`PSM_B8+5:`PSM_B8] = 6'h3f;
         alt_out[`PSM_B8+5:`PSM_B8] = reload_timer_out;
         alt_oe[`PSM_B8+5:`PSM_B8]  = 6'h3f;
      end
      if (ctrl_reg[`PSM_C_PPG]) begin
         alt_sel[`PSM_B8+7:`PSM_B8+6] = 2'h3;
         alt_out[`PSM_B8+7:`PSM_B8+6] = pulse_gen_out;
         alt_oe[`PSM_B8+7:`PSM_B8+6]  = 2'h3;
      end
      // pulse-width outputs only while that channel is outputting
      alt_sel[`PSM_BA+4:`PSM_BA+1] = pulse_width_out_act;
      alt_out[`PSM_BA+4:`PSM_BA+1] = pulse_width_out;
      alt_oe[`PSM_BA+4:`PSM_BA+1]  = pulse_width_out_act;
   end

   // per pin: general port or alternate function
   genvar i;
   generate
      for (i = 0; i < `PSM_NPIN; i = i + 1) begin : g_pin
         if ((i / 8 == 6) || (i / 8 == 9)) begin : g_od
            // open-drain port, released when used as analog input
            wire ana_on;
            assign ana_on = ana_reg[(i / 8 == 9 ? 8 : 0) + i % 8];
            assign pad_out_next[i] = 1'b0;
            assign pad_oe_next[i]  = ~ana_on & dir_reg[i / 8][i % 8] &
                                     ~data_reg[i / 8][i % 8];
         end else begin : g_cmos
            assign pad_out_next[i] = alt_sel[i] ? alt_out[i] :
                                     data_reg[i / 8][i % 8];
            assign pad_oe_next[i]  = alt_sel[i] ? alt_oe[i] :
                                     dir_reg[i / 8][i % 8];
         end
      end
   endgenerate

   // registered pad drive
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pad_out_reg <= {`PSM_NPIN{1'b0}};
         pad_oe_reg  <= {`PSM_NPIN{1'b0}};
      end else begin
         pad_out_reg <= pad_out_next;
         pad_oe_reg  <= pad_oe_next;
      end
   end

   // registered peripheral inputs from synchronised pin levels, analog enables and mode from registers
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lo_in_reg   <= 8'h00;
         hi_in_reg   <= 8'h00;
         rdy_reg     <= 1'b1;
         hrq_reg     <= 1'b0;
         lock_reg    <= 1'b0;
         tin_reg     <= 5'h00;
         cap_reg     <= 4'h0;
         pwc_reg     <= 4'h0;
         irq_lo_reg  <= 2'h0;
         irq_hi_reg  <= 5'h00;
         ana_out_reg <= 16'h0000;
         ext_reg     <= 1'b0;
      end else begin
         lo_in_reg <= ext ? pin_lvl[`PSM_B0+7:`PSM_B0] : 8'h00;
         hi_in_reg <= (ext && bus16) ?
                      pin_lvl[`PSM_B1+7:`PSM_B1] : 8'h00;
         // ready reads as ready when its pin is a port
         rdy_reg   <= (ext && ctrl_reg[`PSM_C_RDY]) ?
                      pin_lvl[`PSM_B5+1] : 1'b1;
         hrq_reg   <= ext & ctrl_reg[`PSM_C_HOLD] & pin_lvl[`PSM_B5+3];
         lock_reg  <= pin_lvl[`PSM_B5+7];
         tin_reg   <= ctrl_reg[`PSM_C_TIN] ?
                      pin_lvl[`PSM_B4+7:`PSM_B4+3] : 5'h00;
         cap_reg   <= pin_lvl[`PSM_BA+3:`PSM_BA];
         pwc_reg   <= pin_lvl[`PSM_BA+4:`PSM_BA+1] & ~pulse_width_out_act;
         // enabled interrupt pins are watched every cycle
         irq_lo_reg <= irqen_reg[1:0] & pin_lvl[`PSM_BA+6:`PSM_BA+5];
         irq_hi_reg <= irqen_reg[6:2] & pin_lvl[`PSM_B4+7:`PSM_B4+3];
         ana_out_reg <= ana_reg;
         ext_reg     <= ext;
      end
   end

   // outputs straight from flip-flops
   assign prdata            = prdata_reg;
   assign pready            = pready_reg;
   assign pslverr           = pslverr_reg;
   assign pad_out           = pad_out_reg;
   assign pad_oe            = pad_oe_reg;
   assign bus_low_byte_in   = lo_in_reg;
   assign bus_high_byte_in  = hi_in_reg;
   assign bus_ready_in      = rdy_reg;
   assign hold_request_in   = hrq_reg;
   assign ram_lock_request  = lock_reg;
   assign reload_timer_in   = tin_reg;
   assign capture_in        = cap_reg;
   assign pulse_width_in    = pwc_reg;
   assign ext_irq_in_lower  = irq_lo_reg;
   assign ext_irq_in_upper  = irq_hi_reg;
   assign analog_in_group_a = ana_out_reg[7:0];
   assign analog_in_group_b = ana_out_reg[15:8];
   assign ext_bus_mode      = ext_reg;
endmodule // psm_top

// File: psm_map.vh
// Notes on behaviour
// - port 0 is plain I/O in single-chip mode, low data byte when bus on.
// - port 1 carries the high data byte only with a 16-bit external bus.
// - port 2 drives low address byte whenever the external bus is on.
// - port 3 drives middle address byte only with bus on and address chosen.
// - port 4 drives upper address lines only with bus on and address chosen.
// - timer input enabled feeds upper five port 4 levels to reload timers.
// - pin 50 drives bus clock only with bus on and clock output enabled.
// - pin 51 is ready input only with bus on and ready enabled.
// - hold on: pin 53 takes hold request, pin 52 drives hold acknowledge.
// - high write strobe needs bus on, 16-bit width and strobe enabled.
// - low write strobe needs bus on and strobe enabled.
// - pin 56 drives read strobe whenever external bus is on.
// - pin 57 feeds RAM write lock and stays general I/O always.
// - ports 6 and 9 select open-drain I/O or analog input per pin.
// - port 7 drives compare outputs when compare output is enabled.
// - port 8 pins 0..5 drive reload timer outputs when enabled.
// - port 8 pins 6,7 drive pulse generator outputs when selected.
// - port A pins 1..4 carry pulse-width output or input, I/O valid while not outputting.
// - port A pins 0..3 feed capture unit while port I/O stays valid.
// - port A pins 5,6 feed interrupt requests when enabled, I/O still valid.
`ifndef PSM_MAP_VH
`define PSM_MAP_VH

// register offsets (byte addresses)
`define PSM_OFF_CTRL    8'h00
`define PSM_OFF_ANA     8'h04
`define PSM_OFF_IRQEN   8'h08
`define PSM_BASE_DATA   2'b01
`define PSM_BASE_DIR    2'b10
`define PSM_BASE_PIN    2'b11
`define PSM_NPORT       4'hb

// control register fields
`define PSM_C_EXT       0
`define PSM_C_BUS16     1
`define PSM_C_MID       2
`define PSM_C_HI        3
`define PSM_C_CLK       4
`define PSM_C_RDY       5
`define PSM_C_HOLD      6
`define PSM_C_WRH       7
`define PSM_C_WRL       8
`define PSM_C_TIN       9
`define PSM_C_CMP       10
`define PSM_C_RT        11
`define PSM_C_PPG       12
`define PSM_C_W         13

// reset values
`define PSM_CTRL_RST    13'h0000
`define PSM_ANA_RST     16'h0000
`define PSM_IRQ_RST     7'h00
`define PSM_PORT_RST    8'h00

// pin base of each port on the pad buses
`define PSM_B0          0
`define PSM_B1          8
`define PSM_B2          16
`define PSM_B3          24
`define PSM_B4          32
`define PSM_B5          40
`define PSM_B6          48
`define PSM_B7          56
`define PSM_B8          64
`define PSM_B9          72
`define PSM_BA          80
`define PSM_NPIN        88

`endif

// File: psm_sync.v
`timescale 1ns/1ps
module psm_sync #(
   parameter WIDTH = 1
) (
   // clock and reset
   input  wire             pclk,
   input  wire             presetn,
   // levels
   input  wire [WIDTH-1:0] d_in,
   output wire [WIDTH-1:0] d_out
);
   reg [WIDTH-1:0] meta_reg;
   reg [WIDTH-1:0] sync_reg;

   // two-stage synchroniser, first stage read only by second
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta_reg <= {WIDTH{1'b0}};
         sync_reg <= {WIDTH{1'b0}};
      end else begin
         meta_reg <= d_in;
         sync_reg <= meta_reg;
      end
   end

   assign d_out = sync_reg;
endmodule // psm_sync

// File: psm_bus_partner.sv
`timescale 1ns/1ps
module psm_bus_partner (
   // clock and reset
   input  logic        pclk,
   input  logic        presetn,
   // pin levels from the device
   input  logic [87:0] pad_out,
   input  logic [87:0] pad_oe,
   // pace and hold wishes of the bench
   input  logic        slow,
   input  logic        hold_want,
   // levels put on the shared pins
   output logic [15:0] data_lvl,
   output logic        rdy_lvl,
   output logic        hrq_lvl
);
   logic [15:0] last_reg;
   logic        rd_on;
   // read strobe low on a driven pin selects the memory
   assign rd_on = pad_oe[46] & ~pad_out[46];
   // last word kept so a released bus shows its inverse
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn) last_reg <= 16'h0000;
      else if (rd_on) last_reg <= {pad_out[23:16], ~pad_out[23:16]};
   // drive data while read, otherwise the inverse of the last word read
   assign data_lvl = rd_on ? {pad_out[23:16], ~pad_out[23:16]} : ~last_reg;
   // a slow memory holds ready low
   assign rdy_lvl = ~slow;
   assign hrq_lvl = hold_want;
endmodule // psm_bus_partner

// File: psm_top_checker.sv
`timescale 1ns/1ps
module psm_top_checker (
   // clock, reset and apb
   input logic        pclk,
   input logic        presetn,
   input logic        psel,
   input logic        penable,
   input logic        pready,
   // pads and bus side
   input logic [87:0] pad_in,
   input logic [87:0] pad_out,
   input logic [87:0] pad_oe,
   input logic [7:0]  bus_low_byte_out,
   input logic [7:0]  bus_low_byte_oe,
   input logic [7:0]  addr_low_byte,
   input logic        read_strobe_n,
   input logic [7:0]  bus_low_byte_in,
   input logic        bus_ready_in,
   input logic        hold_request_in,
   input logic        ram_lock_request,
   input logic [3:0]  capture_in,
   input logic [1:0]  ext_irq_in_lower,
   input logic        ext_bus_mode
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic [1:0] up_cnt_reg;
   // edges since reset release, saturating at three
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn) up_cnt_reg <= 2'd0;
      else if (up_cnt_reg != 2'd3) up_cnt_reg <= up_cnt_reg + 2'd1;
   sequence s_setup; psel && !penable; endsequence
   sequence s_access; psel && penable && pready; endsequence
   property p_apb_answer; s_setup |=> s_access; endproperty
   property p_p0_bus; ext_bus_mode |-> pad_out[7:0] == $past(bus_low_byte_out)
      && pad_oe[7:0] == $past(bus_low_byte_oe); endproperty
   property p_p2_addr; ext_bus_mode |-> pad_oe[23:16] == 8'hff
      && pad_out[23:16] == $past(addr_low_byte); endproperty
   property p_rd_strobe; ext_bus_mode |-> pad_oe[46]
      && pad_out[46] == $past(read_strobe_n); endproperty
   property p_wi_follow; up_cnt_reg == 2'd3
      |-> ram_lock_request == $past(pad_in[47], 3); endproperty
   property p_cap_follow; up_cnt_reg == 2'd3
      |-> capture_in == $past(pad_in[83:80], 3); endproperty
   property p_irq_lower; up_cnt_reg == 2'd3
      |-> (ext_irq_in_lower & ~$past(pad_in[86:85], 3)) == 2'b00; endproperty
   property p_no_bus_in; !ext_bus_mode [*3] |-> bus_ready_in
      && !hold_request_in && bus_low_byte_in == 8'h00; endproperty
   property p_open_drain;
      pad_out[55:48] == 8'h00 && pad_out[79:72] == 8'h00; endproperty
   a_apb_answer: assert property (p_apb_answer)
      else $error("no ready after setup");
   a_p0_bus: assert property (p_p0_bus)
      else $error("port 0 not on bus");
   a_p2_addr: assert property (p_p2_addr)
      else $error("port 2 not on address");
   a_rd_strobe: assert property (p_rd_strobe)
      else $error("read strobe pin wrong");
   a_wi_follow: assert property (p_wi_follow)
      else $error("write lock input wrong");
   a_cap_follow: assert property (p_cap_follow)
      else $error("capture input wrong");
   a_irq_lower: assert property (p_irq_lower)
      else $error("interrupt input without pin level");
   a_no_bus_in: assert property (p_no_bus_in)
      else $error("bus inputs live in single chip");
   a_open_drain: assert property (p_open_drain)
      else $error("open drain port drives high");
endmodule // psm_top_checker

bind psm_top psm_top_checker i_psm_top_checker (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pready(pready), .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe),
   .bus_low_byte_out(bus_low_byte_out), .bus_low_byte_oe(bus_low_byte_oe),
   .addr_low_byte(addr_low_byte), .read_strobe_n(read_strobe_n),
   .bus_low_byte_in(bus_low_byte_in), .bus_ready_in(bus_ready_in),
   .hold_request_in(hold_request_in), .ram_lock_request(ram_lock_request),
   .capture_in(capture_in), .ext_irq_in_lower(ext_irq_in_lower),
   .ext_bus_mode(ext_bus_mode));

// File: psm_top_bench.sv
`timescale 1ns/1ps
module psm_top_bench;
   // apb, pads and far side
   logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [7:0]  paddr = 0;
   logic [31:0] pwdata = 0, prdata, rd;
   logic        pready, pslverr, er, rdy_lvl, hrq_lvl;
   logic        slow = 0, hold_want = 0;
   logic [87:0] pad_in, pad_out, pad_oe, far, fl = 0, e_out, e_oe;
   logic [84:0] src = 0;
   logic [15:0] data_lvl, ana;
   logic [7:0]  bli, bhi, ana_a, ana_b, pd [11], pdir [11];
   logic [7:0]  adr [6] = '{8'h00, 8'h04, 8'h08, 8'h40, 8'h0c, 8'h6c};
   logic [4:0]  rti, iru;
   logic [3:0]  capi, pwi;
   logic [1:0]  irl;
   logic        bri, hri, rli, ebm;
   logic [12:0] ctrl;
   logic [6:0]  irqen;
   logic [55:0] ein;
   int          bad_count = 0, checks_done = 0;

   psm_top i_psm_top (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .pad_in(pad_in),
      .pad_out(pad_out), .pad_oe(pad_oe),
      .bus_low_byte_out(src[7:0]), .bus_low_byte_oe(src[15:8]),
      .bus_high_byte_out(src[23:16]), .bus_high_byte_oe(src[31:24]),
      .addr_low_byte(src[39:32]), .addr_mid_byte(src[47:40]),
      .addr_upper_lines_a(src[50:48]), .addr_upper_lines_b(src[55:51]),
      .bus_clk_out(src[56]), .read_strobe_n(src[57]),
      .write_strobe_hi_n(src[58]), .write_strobe_lo_n(src[59]),
      .hold_ack_out(src[60]), .bus_low_byte_in(bli),
      .bus_high_byte_in(bhi), .bus_ready_in(bri), .hold_request_in(hri),
      .ram_lock_request(rli), .compare_out(src[68:61]),
      .reload_timer_out(src[74:69]), .pulse_gen_out(src[76:75]),
      .pulse_width_out(src[80:77]), .pulse_width_out_act(src[84:81]),
      .reload_timer_in(rti), .capture_in(capi), .pulse_width_in(pwi),
      .ext_irq_in_lower(irl), .ext_irq_in_upper(iru),
      .analog_in_group_a(ana_a), .analog_in_group_b(ana_b),
      .ext_bus_mode(ebm));
   psm_bus_partner i_psm_bus_partner (
      .pclk(pclk), .presetn(presetn), .pad_out(pad_out), .pad_oe(pad_oe),
      .slow(slow), .hold_want(hold_want), .data_lvl(data_lvl),
      .rdy_lvl(rdy_lvl), .hrq_lvl(hrq_lvl));
   // wire level: the device where it drives, else the far side
   assign far = {fl[87:44], hrq_lvl, fl[42], rdy_lvl, fl[40:16], data_lvl};
   assign pad_in = (pad_oe & pad_out) | (~pad_oe & far);
   // clock
   initial forever #4 pclk = ~pclk;

   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [87:0] e, s);
      checks_done++;
      if (s !== e) begin
         bad_count++;
         $display("mismatch %s expected %h seen %h", nm, e, s);
      end
   endtask

   // one apb transfer, waiting for ready under a bound
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      int n = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
      if (n >= 50) begin
         bad_count++;
         report_and_stop;
      end
   endtask

   // expected pads and peripheral inputs from the settings
   task automatic model;
      logic x;
      x = ctrl[0];
      for (int p = 0; p < 11; p++) begin
         e_out[p*8+:8] = pd[p];
         e_oe[p*8+:8] = pdir[p];
      end
      e_oe[55:48] = pdir[6] & ~pd[6] & ~ana[7:0];
      e_oe[79:72] = pdir[9] & ~pd[9] & ~ana[15:8];
      e_out[55:48] = 8'h00;
      e_out[79:72] = 8'h00;
      // ready and hold request pins are released as inputs
      if (x & ctrl[5]) e_oe[41] = 1'b0;
      if (x & ctrl[6]) e_oe[43] = 1'b0;
      if (x) {e_oe[7:0], e_out[7:0]} = src[15:0];
      if (x & ctrl[1]) {e_oe[15:8], e_out[15:8]} = src[31:16];
      if (x) {e_oe[23:16], e_out[23:16]} = {8'hff, src[39:32]};
      if (x & ctrl[2]) {e_oe[31:24], e_out[31:24]} = {8'hff, src[47:40]};
      if (x & ctrl[3]) {e_oe[39:32], e_out[39:32]} = {8'hff, src[55:48]};
      if (x & ctrl[4]) {e_oe[40], e_out[40]} = {1'b1, src[56]};
      if (x & ctrl[6]) {e_oe[42], e_out[42]} = {1'b1, src[60]};
      if (x & ctrl[1] & ctrl[7]) {e_oe[44], e_out[44]} = {1'b1, src[58]};
      if (x & ctrl[8]) {e_oe[45], e_out[45]} = {1'b1, src[59]};
      if (x) {e_oe[46], e_out[46]} = {1'b1, src[57]};
      if (ctrl[10]) {e_oe[63:56], e_out[63:56]} = {8'hff, src[68:61]};
      if (ctrl[11]) {e_oe[69:64], e_out[69:64]} = {6'h3f, src[74:69]};
      if (ctrl[12]) {e_oe[71:70], e_out[71:70]} = {2'h3, src[76:75]};
      for (int n = 0; n < 4; n++)
         if (src[81+n]) {e_oe[81+n], e_out[81+n]} = {1'b1, src[77+n]};
      ein = {x ? pad_in[7:0] : 8'h00, (x & ctrl[1]) ? pad_in[15:8] : 8'h00,
             (x & ctrl[5]) ? pad_in[41] : 1'b1,
             x & ctrl[6] & pad_in[43], pad_in[47],
             ctrl[9] ? pad_in[39:35] : 5'h00, pad_in[83:80],
             pad_in[84:81] & ~src[84:81],
             pad_in[86:85] & irqen[1:0], pad_in[39:35] & irqen[6:2], ana, x};
   endtask

   initial begin
      void'($urandom(32'hc06d6307));
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      // reset values, unmapped and out-of-range places
      for (int i = 0; i < 6; i++) begin
         apb(1'b0, adr[i], 32'h0);
         chk("reset read", {i > 3, 32'h0}, {er, rd});
      end
      apb(1'b1, 8'h0c, '1);
      chk("unmapped write", 88'h1, er);
      apb(1'b1, 8'hc0, '1);
      chk("pin write", 88'h0, er);
      chk("reset pads", 88'h0, pad_oe);
      $display("test reset done");
      // random port setup, then 24 random mode mixes
      for (int p = 0; p < 11; p++) begin
         pd[p] = 8'($urandom);
         pdir[p] = 8'($urandom);
         apb(1'b1, 8'h40 + 8'(4 * p), {24'h0, pd[p]});
         apb(1'b1, 8'h80 + 8'(4 * p), {24'h0, pdir[p]});
      end
      ana = 16'($urandom);
      // interrupts only on pins that the port leaves as inputs
      irqen = 7'($urandom) & ~{pdir[4][7:3], pdir[10][6:5]};
      apb(1'b1, 8'h04, {16'h0, ana});
      apb(1'b1, 8'h08, {25'h0, irqen});
      for (int i = 0; i < 24; i++) begin
         ctrl = 13'($urandom);
         ctrl[0] = i[0];
         src <= 85'({$urandom, $urandom, $urandom});
         fl <= 88'({$urandom, $urandom, $urandom});
         slow <= 1'($urandom);
         hold_want <= 1'($urandom);
         apb(1'b1, 8'h00, {19'h0, ctrl});
         repeat (6) @(posedge pclk);
         model;
         chk("pad drive", e_out & e_oe, pad_out & pad_oe);
         chk("pad enable", e_oe, pad_oe);
         chk("inputs", ein, {bli, bhi, bri, hri, rli, rti, capi, pwi, irl,
                             iru, ana_b, ana_a, ebm});
         apb(1'b0, 8'he8, 32'h0);
         chk("pin read", {24'h0, pad_in[87:80]}, rd);
      end
      $display("test mux done");
      // second reset in mid-run
      presetn <= 1'b0;
      repeat (6) @(posedge pclk);
      chk("pads after reset", 88'h0, pad_oe);
      chk("ready in reset", 88'h1, bri);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(1'b0, 8'h00, 32'h0);
      chk("ctrl after reset", 88'h0, rd);
      $display("test rereset done");
      report_and_stop;
   end
endmodule // psm_top_bench
